// *** inc/psm_regs.svh ***
// constants for the power save mode sequencer: offsets, fields, encodings
// assumes a plain one-cycle strobe register port, 32-bit data
// Functional notes
// - reset starts in default run state, all clock groups on
// - wake returns to the entry run mode
// - reset exit always lands in default run
// - I/O configuration held in every save mode
// - sleep depth selects which clock groups stop
// - only clocked modules' interrupts wake sleep
// - sleep entry: wfi with deep sleep select clear
// - sleep on isr return also enters mode
// - unmasked sufficient-priority interrupt ends sleep
// - wait/retention: only slow clocks, core powered
// - wfi with deep sleep, no backup: wait/retention
// - enabled async sources, eic and ast end wait/retention
// - async wake raises wake irq, records cause
// - backup powers core off, slow clock kept
// - wfi with deep sleep and backup: backup
// - brownout, watchdog, pin reset end backup
// - eic, ast, brownout and watchdog irqs also end backup, with no enable
// - slow clock select picks rc or crystal
// - reset exit: sequence, wait supply, flag cause
// - wake exit: core reset, prior mode, flags
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH
`define PSM_OFS_CTRL      4'h0
`define PSM_OFS_ASYNC_WAKE_ENABLE      4'h1
`define PSM_OFS_WAKE_CAUSE    4'h2
`define PSM_OFS_RESET_CAUSE    4'h3
`define PSM_OFS_BWCAUSE   4'h4
`define PSM_OFS_STATUS    4'h5
`define PSM_OFS_RUNMODE   4'h6
`define PSM_CTRL_DEPTH_LO 0
`define PSM_CTRL_RET      2
`define PSM_CTRL_BACKUP_SELECT     3
`define PSM_CTRL_SLOW_CLOCK_SOURCE_SELECT    4
`define PSM_CTRL_WAKEIE   5
`define PSM_DEPTH_CPU     2'h0
`define PSM_DEPTH_BUS     2'h1
`define PSM_DEPTH_PER     2'h2
`define PSM_DEPTH_OSC     2'h3
`define PSM_RC_ANALOG_SUPPLY_BROWNOUT      0
`define PSM_RC_CORE_SUPPLY_BROWNOUT      1
`define PSM_RC_WDT        2
`define PSM_RC_PIN        3
`define PSM_RC_BACKUP_SELECT       4
`define PSM_BW_EIC        0
`define PSM_BW_ANALOG_SUPPLY_BROWNOUT      1
`define PSM_BW_CORE_SUPPLY_BROWNOUT      2
`define PSM_BW_AST        3
`define PSM_BW_WDT        4
`define PSM_RST_CYCLES    8'h10
`define PSM_ZERO32        32'h0000_0000
`endif

// *** inc/psm_pkg.sv ***
// types of the power save mode sequencer
// assumes psm_regs.svh for numeric constants
package psm_pkg;
  typedef enum logic [6:0] {
    PSM_RUN    = 7'b000_0001,
    PSM_SLEEP  = 7'b000_0010,
    PSM_WAIT   = 7'b000_0100,
    PSM_RETAIN = 7'b000_1000,
    PSM_BACKUP = 7'b001_0000,
    PSM_CRST   = 7'b010_0000,
    PSM_SUPWT  = 7'b100_0000
  } psm_state_t;
endpackage : psm_pkg

// *** inc/psm_gate_if.sv ***
// clock gate bundle between sequencer and gate module
// assumes single clock domain
`timescale 1ns/1ps
interface psm_gate_if;
  logic [1:0] depth;
  logic       in_sleep;
  logic       in_deep;
  logic       slow_clock_source_select;
  logic       cpu_en;
  logic       bus_en;
  logic       per_en;
  logic       osc_en;
  logic       rc32_en;
  logic       osc32_en;
  modport seq  (output depth, in_sleep, in_deep, slow_clock_source_select,
                input cpu_en, bus_en, per_en, osc_en, rc32_en, osc32_en);
  modport gate (input depth, in_sleep, in_deep, slow_clock_source_select,
                output cpu_en, bus_en, per_en, osc_en, rc32_en, osc32_en);
endinterface : psm_gate_if

// *** rtl/psm_gate.sv ***
// clock group enables from save mode and sleep depth
// assumes interface driven by the sequencer, same clock
`timescale 1ns/1ps
`include "psm_regs.svh"
module psm_gate (
  psm_gate_if.gate g  // gate bundle
);
  import psm_pkg::*;
  always_comb begin
    g.cpu_en = !(g.in_sleep || g.in_deep);
    g.bus_en = !(g.in_deep || (g.in_sleep && g.depth >= `PSM_DEPTH_BUS));
    g.per_en = !(g.in_deep || (g.in_sleep && g.depth >= `PSM_DEPTH_PER));
    g.osc_en = !(g.in_deep || (g.in_sleep && g.depth == `PSM_DEPTH_OSC));
    g.rc32_en  = !g.slow_clock_source_select;
    g.osc32_en = g.slow_clock_source_select;
  end
endmodule : psm_gate

// *** rtl/psm_seq.sv ***
// power save mode sequencer top
// assumes core wfi/isr-return pulses and irq levels on core_clk_i;
// wake and reset sources from pins or other domains are synchronised here
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "psm_regs.svh"
module psm_seq
  import psm_pkg::*;
#(
  parameter int NAWK = 8  // async wake source count
) (
  input  wire logic             core_clk_i,      // 250 MHz clock
  input  wire logic             rst_n_i,         // async reset, low
  input  wire logic [3:0]       addr_i,          // register index
  input  wire logic [31:0]      wdata_i,         // write data
  input  wire logic             wr_i,            // write strobe
  input  wire logic             rd_i,            // read strobe
  output logic      [31:0]      rdata_o,         // read data
  input  wire logic             deep_sleep_select_i, // core deep sleep
  input  wire logic             wfi_i,           // wfi executed pulse
  input  wire logic             sleep_on_isr_return_i, // exit option
  input  wire logic             isr_last_ret_i,  // lowest isr return
  input  wire logic             irq_pending_i,   // unmasked irq, prio ok
  input  wire logic             irq_src_clocked_i, // irq source clocked
  input  wire logic [NAWK-1:0]  async_wake_i,    // async wake sources
  input  wire logic             eic_wake_i,      // ext irq line edge
  input  wire logic             ast_wake_i,      // timer event
  input  wire logic             analog_supply_brownout_irq_i,     // analog brownout irq
  input  wire logic             core_supply_brownout_irq_i,     // core brownout irq
  input  wire logic             wdt_irq_i,       // watchdog irq
  input  wire logic             analog_supply_brownout_rst_i,     // analog brownout reset
  input  wire logic             core_supply_brownout_rst_i,     // core brownout reset
  input  wire logic             wdt_rst_i,       // watchdog reset
  input  wire logic             pin_rst_i,       // external reset pin
  input  wire logic             supply_ok_i,     // core supply stable
  input  wire logic [NAWK-1:0]  irq_en_i,        // peripheral wake irq en
  output logic                  cpu_clk_en_o,    // cpu clock enable
  output logic                  bus_clk_en_o,    // bus clocks enable
  output logic                  per_clk_en_o,    // peripheral/generic clk
  output logic                  osc_en_o,        // fast oscillators/loops
  output logic                  sys_rc_en_o,     // system rc osc
  output logic                  slow_rc_en_o,    // slow rc osc clocking
  output logic                  slow_xtal_en_o,  // slow crystal clocking
  output logic                  core_pwr_o,      // core domain power
  output logic                  core_rst_n_o,    // core domain reset, low
  output logic                  io_hold_o,       // freeze i/o config
  output logic                  wake_irq_o,      // power manager wake irq
  output logic [NAWK-1:0]       periph_irq_o,    // per-peripheral wake irq
  output logic                  run_default_o,   // default run mode
  output logic                  awn_block_o      // autonomous wake blocked
);
  localparam int NS = NAWK + 9;
  typedef struct packed {
    psm_state_t  st;
    logic [5:0]  ctrl;
    logic [NAWK-1:0] async_wake_enable;
    logic [NAWK-1:0] wake_cause;
    logic [4:0]  reset_cause;
    logic [4:0]  bwcause;
    logic        run_mode;
    logic        saved_mode;
    logic        rst_exit;
    logic [7:0]  cnt;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic        wirq;
    logic [NAWK-1:0] pirq;
    logic [31:0] rdata;
  } psm_regs_t;
  psm_regs_t r_reg, r_next;
  psm_gate_if gif ();
  psm_gate u_gate (.g(gif));
  logic [NS-1:0] raw;
  logic [NAWK-1:0] aw_s;
  logic eic_s, ast_s, b33i, b18i, wdti, b33r, b18r, wdtr, pinr;
  logic any_rst, bk_wake, sleep_req;
  assign raw = {async_wake_i, eic_wake_i, ast_wake_i, analog_supply_brownout_irq_i,
                core_supply_brownout_irq_i, wdt_irq_i, analog_supply_brownout_rst_i, core_supply_brownout_rst_i,
                wdt_rst_i, pin_rst_i};
  assign {aw_s, eic_s, ast_s, b33i, b18i, wdti, b33r, b18r, wdtr, pinr}
    = r_reg.s2;
  assign any_rst = b33r | b18r | wdtr | pinr;
  assign bk_wake = eic_s | b33i | b18i | ast_s | wdti;
  assign sleep_req = wfi_i | (sleep_on_isr_return_i & isr_last_ret_i);
  assign gif.depth    = r_reg.ctrl[`PSM_CTRL_RET-1:`PSM_CTRL_DEPTH_LO];
  assign gif.in_sleep = r_reg.st == PSM_SLEEP;
  assign gif.in_deep  = r_reg.st inside {PSM_WAIT, PSM_RETAIN, PSM_BACKUP,
                                          PSM_CRST, PSM_SUPWT};
  assign gif.slow_clock_source_select    = r_reg.ctrl[`PSM_CTRL_SLOW_CLOCK_SOURCE_SELECT];
  always_comb begin
    r_next = r_reg;
    r_next.s1 = raw;
    r_next.s2 = r_reg.s1;
    r_next.wirq = 1'b0;
    r_next.pirq = '0;
    r_next.rdata = `PSM_ZERO32;
    if (wr_i) begin
      case (addr_i)
        `PSM_OFS_CTRL: r_next.ctrl = wdata_i[5:0];
        `PSM_OFS_ASYNC_WAKE_ENABLE: r_next.async_wake_enable = wdata_i[NAWK-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `PSM_OFS_CTRL:    r_next.rdata = {26'h000_0000, r_reg.ctrl};
        `PSM_OFS_ASYNC_WAKE_ENABLE:    r_next.rdata = {{(32-NAWK){1'b0}}, r_reg.async_wake_enable};
        `PSM_OFS_WAKE_CAUSE:  r_next.rdata = {{(32-NAWK){1'b0}}, r_reg.wake_cause};
        `PSM_OFS_RESET_CAUSE:  r_next.rdata = {27'h000_0000, r_reg.reset_cause};
        `PSM_OFS_BWCAUSE: r_next.rdata = {27'h000_0000, r_reg.bwcause};
        `PSM_OFS_STATUS:  r_next.rdata = {25'h000_0000, r_reg.st};
        `PSM_OFS_RUNMODE: r_next.rdata = {31'h0000_0000, r_reg.run_mode};
        default:          r_next.rdata = `PSM_ZERO32;
      endcase
    end
    if (wr_i && addr_i == `PSM_OFS_RUNMODE && r_reg.st == PSM_RUN)
      r_next.run_mode = wdata_i[0];
    case (r_reg.st)
      PSM_RUN: begin
        if (any_rst) begin
          r_next.reset_cause = {1'b0, pinr, wdtr, b18r, b33r};
          r_next.rst_exit = 1'b1;
          r_next.cnt = `PSM_RST_CYCLES;
          r_next.st = PSM_CRST;
        end else if (sleep_req) begin
          r_next.saved_mode = r_reg.run_mode;
          if (!deep_sleep_select_i)
            r_next.st = PSM_SLEEP;
          else if (r_reg.ctrl[`PSM_CTRL_BACKUP_SELECT])
            r_next.st = PSM_BACKUP;
          else if (r_reg.ctrl[`PSM_CTRL_RET])
            r_next.st = PSM_RETAIN;
          else
            r_next.st = PSM_WAIT;
        end
      end
      PSM_SLEEP: begin
        if (any_rst) begin
          r_next.reset_cause = {1'b0, pinr, wdtr, b18r, b33r};
          r_next.rst_exit = 1'b1;
          r_next.cnt = `PSM_RST_CYCLES;
          r_next.st = PSM_CRST;
        end else if (irq_pending_i && irq_src_clocked_i) begin
          r_next.run_mode = r_reg.saved_mode;
          r_next.st = PSM_RUN;
        end
      end
      PSM_WAIT, PSM_RETAIN: begin
        if (any_rst) begin
          r_next.reset_cause = {1'b0, pinr, wdtr, b18r, b33r};
          r_next.rst_exit = 1'b1;
          r_next.cnt = `PSM_RST_CYCLES;
          r_next.st = PSM_CRST;
        end else if (|((aw_s & r_reg.async_wake_enable)) || eic_s || ast_s) begin
          r_next.wake_cause = aw_s & r_reg.async_wake_enable;
          if (r_reg.ctrl[`PSM_CTRL_WAKEIE])
            r_next.wirq = 1'b1;
          else
            r_next.pirq = aw_s & r_reg.async_wake_enable & irq_en_i;
          r_next.run_mode = r_reg.saved_mode;
          r_next.st = PSM_RUN;
        end
      end
      PSM_BACKUP: begin
        r_next.cnt = `PSM_RST_CYCLES;
        if (any_rst) begin
          r_next.reset_cause = {1'b0, pinr, wdtr, b18r, b33r};
          r_next.rst_exit = 1'b1;
          r_next.st = PSM_CRST;
        end else if (bk_wake) begin
          r_next.reset_cause = 5'h10;
          r_next.bwcause = {wdti, ast_s, b18i, b33i, eic_s};
          r_next.rst_exit = 1'b0;
          r_next.st = PSM_CRST;
        end
      end
      PSM_CRST: begin
        if (r_reg.cnt == 8'h00)
          r_next.st = PSM_SUPWT;
        else
          r_next.cnt = r_reg.cnt - 8'h01;
      end
      PSM_SUPWT: begin
        if (supply_ok_i) begin
          r_next.run_mode = r_reg.rst_exit ? 1'b0 : r_reg.saved_mode;
          r_next.st = PSM_RUN;
        end
      end
      default: r_next.st = PSM_RUN;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '{st: PSM_RUN, ctrl: 6'h00, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end
  always_comb begin
    cpu_clk_en_o   = gif.cpu_en;
    bus_clk_en_o   = gif.bus_en;
    per_clk_en_o   = gif.per_en;
    osc_en_o       = gif.osc_en;
    sys_rc_en_o    = !gif.in_deep;
    slow_rc_en_o   = gif.rc32_en;
    slow_xtal_en_o = gif.osc32_en;
    core_pwr_o     = r_reg.st != PSM_BACKUP;
    core_rst_n_o   = !(r_reg.st inside {PSM_BACKUP, PSM_CRST, PSM_SUPWT});
    io_hold_o      = r_reg.st != PSM_RUN;
    wake_irq_o     = r_reg.wirq;
    periph_irq_o   = r_reg.pirq;
    rdata_o        = r_reg.rdata;
    run_default_o  = !r_reg.run_mode;
    awn_block_o    = r_reg.st == PSM_RETAIN;
  end
endmodule : psm_seq

// *** bench/psm_seq_props.sv ***
// port assertions for the power save mode sequencer
// assumes binding onto psm_seq, one clock domain
`timescale 1ns/1ps
module psm_seq_props (
  input wire logic core_clk_i,        // clock
  input wire logic rst_n_i,           // async reset, low
  input wire logic irq_pending_i,     // unmasked irq
  input wire logic irq_src_clocked_i, // irq source clocked
  input wire logic supply_ok_i,       // core supply stable
  input wire logic cpu_clk_en_o,      // cpu clock
  input wire logic bus_clk_en_o,      // bus clocks
  input wire logic per_clk_en_o,      // peripheral clocks
  input wire logic osc_en_o,          // fast oscillators
  input wire logic sys_rc_en_o,       // system rc
  input wire logic slow_rc_en_o,      // slow rc
  input wire logic slow_xtal_en_o,    // slow crystal
  input wire logic core_pwr_o,        // core power
  input wire logic core_rst_n_o,      // core reset, low
  input wire logic io_hold_o,         // i/o freeze
  input wire logic wake_irq_o         // wake irq pulse
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // sleep: cpu stopped while the system rc still runs
  sequence s_sleep_irq;
    !cpu_clk_en_o && sys_rc_en_o && irq_pending_i;
  endsequence
  sequence s_rst_low;
    !core_rst_n_o [*8];
  endsequence
  a_hold_stopped: assert property (!cpu_clk_en_o |-> io_hold_o)
    else $error("io not held with cpu stopped");
  a_sleep_wake: assert property (
    s_sleep_irq ##0 irq_src_clocked_i |=> cpu_clk_en_o)
    else $error("clocked irq did not end sleep");
  a_unclocked_irq: assert property (
    s_sleep_irq ##0 !irq_src_clocked_i |=> !cpu_clk_en_o)
    else $error("unclocked irq ended sleep");
  a_depth_bus: assert property (!bus_clk_en_o |-> !cpu_clk_en_o)
    else $error("bus stopped with cpu running");
  a_depth_per: assert property (!per_clk_en_o |-> !bus_clk_en_o)
    else $error("peripherals stopped with bus running");
  a_depth_osc: assert property (!osc_en_o |-> !per_clk_en_o)
    else $error("oscillators stopped with peripherals running");
  a_slow_pick: assert property (slow_xtal_en_o != slow_rc_en_o)
    else $error("slow clock selection not exclusive");
  a_core_off: assert property (
    !core_pwr_o |-> !cpu_clk_en_o && io_hold_o && !sys_rc_en_o)
    else $error("clocks alive with core off");
  a_wake_pulse: assert property (wake_irq_o |=> !wake_irq_o)
    else $error("wake irq longer than one cycle");
  a_rst_len: assert property ($fell(core_rst_n_o) |-> s_rst_low)
    else $error("core reset too short");
  a_rst_release: assert property (
    $rose(core_rst_n_o) |-> $past(supply_ok_i))
    else $error("core reset released before supply ok");
endmodule : psm_seq_props
bind psm_seq psm_seq_props u_props (.core_clk_i, .rst_n_i, .irq_pending_i,
  .irq_src_clocked_i, .supply_ok_i, .cpu_clk_en_o, .bus_clk_en_o,
  .per_clk_en_o, .osc_en_o, .sys_rc_en_o, .slow_rc_en_o, .slow_xtal_en_o,
  .core_pwr_o, .core_rst_n_o, .io_hold_o, .wake_irq_o);

// *** bench/psm_core_model.sv ***
// core and core supply model facing the sequencer
// assumes one clock; go_i is a one-cycle request from the bench
`timescale 1ns/1ps
module psm_core_model (
  input  wire logic clk_i,       // core clock
  input  wire logic rst_n_i,     // async reset, low
  input  wire logic go_i,        // bench asks for a wfi
  input  wire logic core_pwr_i,  // core domain power
  output logic      wfi_o,       // wfi executed pulse
  output logic      supply_ok_o  // core supply stable
);
  logic [2:0] ramp_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wfi_o    <= 1'b0;
      ramp_reg <= 3'h0;
    end else begin
      wfi_o <= go_i;
      // supply ramps only while powered, drops at once when cut
      if (!core_pwr_i) ramp_reg <= 3'h0;
      else if (ramp_reg != 3'h7) ramp_reg <= ramp_reg + 3'h1;
    end
  end
  assign supply_ok_o = (ramp_reg == 3'h7);
endmodule : psm_core_model

// *** bench/tb.sv ***
// self-checking bench for the power save mode sequencer
// assumes psm_core_model as core and supply, checker bound to psm_seq
`timescale 1ns/1ps
`include "psm_regs.svh"
module tb;
  import psm_pkg::*;
  localparam int NAWK = 8;
  logic core_clk_i, rst_n_i, wr_i, rd_i, deep_sleep_select_i, wfi_i, go;
  logic sleep_on_isr_return_i, isr_last_ret_i, irq_pending_i;
  logic irq_src_clocked_i, eic_wake_i, ast_wake_i, analog_supply_brownout_irq_i;
  logic core_supply_brownout_irq_i, wdt_irq_i, analog_supply_brownout_rst_i, core_supply_brownout_rst_i, wdt_rst_i;
  logic pin_rst_i, supply_ok_i, cpu_clk_en_o, bus_clk_en_o, per_clk_en_o;
  logic osc_en_o, sys_rc_en_o, slow_rc_en_o, slow_xtal_en_o, core_pwr_o;
  logic core_rst_n_o, io_hold_o, wake_irq_o, run_default_o, awn_block_o;
  logic [3:0]      addr_i, rs;
  logic [4:0]      bw;
  logic [31:0]     wdata_i, rdata_o, rv, c;
  logic [NAWK-1:0] async_wake_i, irq_en_i, periph_irq_o, m;
  int mismatches = 0, n_checks = 0, cyc = 0, nw = 0, np = 0, w0, p0, i;
  assign {wdt_irq_i, ast_wake_i, core_supply_brownout_irq_i, analog_supply_brownout_irq_i, eic_wake_i} = bw;
  assign {pin_rst_i, wdt_rst_i, core_supply_brownout_rst_i, analog_supply_brownout_rst_i} = rs;
  psm_seq #(.NAWK(NAWK)) dut (.*);
  psm_core_model u_core (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .go_i(go),
    .core_pwr_i(core_pwr_o), .wfi_o(wfi_i), .supply_ok_o(supply_ok_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (wake_irq_o === 1'b1) nw++;
    if (|periph_irq_o === 1'b1) np++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    tick(1);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    tick(1);
    addr_i <= a;
    rd_i   <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd_reg
  task automatic wait_run();
    for (int k = 0; k < 200 && io_hold_o !== 1'b0; k++) tick(1);
    #1;
  endtask : wait_run
  task automatic enter(input logic [31:0] ctl, input logic dp);
    wr_reg(`PSM_OFS_CTRL, ctl);
    deep_sleep_select_i <= dp;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(3);
    #1;
  endtask : enter
  task automatic wake_sleep();
    tick(1);
    irq_pending_i     <= 1'b1;
    irq_src_clocked_i <= 1'b1;
    wait_run();
    irq_pending_i <= 1'b0;
  endtask : wake_sleep
  // expected {sys_rc, osc, per, bus, cpu} in sleep for a depth
  function automatic logic [4:0] exp_clk(input logic [1:0] d);
    exp_clk = {1'b1, d < 2'h3, d < 2'h2, d < 2'h1, 1'b0};
  endfunction : exp_clk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    {rst_n_i, wr_i, rd_i, deep_sleep_select_i, go} = 5'h0;
    {sleep_on_isr_return_i, isr_last_ret_i, irq_pending_i} = 3'h0;
    {irq_src_clocked_i, addr_i, wdata_i, bw, rs} = '0;
    async_wake_i = '0;
    irq_en_i = '1;
    void'($urandom(32'h45d0));
    tick(10);
    rst_n_i <= 1'b1;
    #1 chk({sys_rc_en_o, osc_en_o, per_clk_en_o, bus_clk_en_o, cpu_clk_en_o,
            io_hold_o, core_pwr_o, core_rst_n_o}, 8'hfb);
    rd_reg(`PSM_OFS_STATUS, rv);
    chk(rv, 32'(PSM_RUN));
    wr_reg(4'hf, $urandom());
    rd_reg(4'hf, rv);
    chk(rv, 32'h0000_0000);
    $display("test reset done");
    for (int d = 0; d < 4; d++) begin
      enter(32'(d), 1'b0);
      chk({sys_rc_en_o, osc_en_o, per_clk_en_o, bus_clk_en_o, cpu_clk_en_o,
           io_hold_o}, {exp_clk(2'(d)), 1'b1});
      irq_pending_i     <= 1'b1;
      irq_src_clocked_i <= 1'b0;
      tick(4);
      #1 chk(cpu_clk_en_o, 1'b0);
      wake_sleep();
      chk(cpu_clk_en_o, 1'b1);
    end
    tick(1);
    sleep_on_isr_return_i <= 1'b1;
    isr_last_ret_i        <= 1'b1;
    tick(1);
    isr_last_ret_i <= 1'b0;
    tick(3);
    #1 chk(cpu_clk_en_o, 1'b0);
    wake_sleep();
    sleep_on_isr_return_i <= 1'b0;
    $display("test sleep done");
    for (int r = 0; r < 2; r++) begin
      i = $urandom_range(NAWK - 1);
      c = 32'($urandom_range(1)) << 5 | 32'(r) << 2;
      m = '0;
      m[i] = 1'b1;
      wr_reg(`PSM_OFS_ASYNC_WAKE_ENABLE, 32'(m));
      enter(c, 1'b1);
      chk({sys_rc_en_o, osc_en_o, per_clk_en_o, bus_clk_en_o, cpu_clk_en_o,
           core_pwr_o, awn_block_o}, {6'h01, r[0]});
      w0 = nw;
      p0 = np;
      tick(1);
      async_wake_i <= ~m;
      tick(6);
      #1 chk(io_hold_o, 1'b1);
      async_wake_i <= m;
      wait_run();
      async_wake_i <= '0;
      chk(32'(nw - w0), c[5] ? 32'h1 : 32'h0);
      chk(32'(np - p0), c[5] ? 32'h0 : 32'h1);
      rd_reg(`PSM_OFS_WAKE_CAUSE, rv);
      chk(rv, 32'(m));
    end
    $display("test wait done");
    for (int k = 0; k < 9; k++) begin
      c = 32'($urandom_range(1)) << 4 | 32'h8;
      wr_reg(`PSM_OFS_RUNMODE, 32'h1);
      enter(c, 1'b1);
      chk({core_pwr_o, io_hold_o, slow_xtal_en_o, slow_rc_en_o},
          {2'h1, c[4], !c[4]});
      tick(1);
      if (k < 5) bw <= 5'h01 << k;
      else rs <= 4'h1 << (k - 5);
      tick(4);
      {bw, rs} <= '0;
      wait_run();
      rd_reg(`PSM_OFS_RESET_CAUSE, rv);
      chk(rv, k < 5 ? 32'h10 : 32'h1 << (k - 5));
      rd_reg(`PSM_OFS_RUNMODE, rv);
      chk(rv, k < 5 ? 32'h1 : 32'h0);
      chk(32'(run_default_o), k < 5 ? 32'h0 : 32'h1);
      if (k < 5) rd_reg(`PSM_OFS_BWCAUSE, rv);
      if (k < 5) chk(rv, 32'h1 << k);
    end
    $display("test backup done");
    final_report();
  end
endmodule : tb
